// ---- hdl/nand_ctl.sv ----
// host-side controller for status read, identification read and reset of a nand flash
//
// Notes on behaviour
// - after command 70h every read returns the status byte
// - after polling during a page read, write 00h before data reads
// - identification entered by command 90h then one address byte 00h
// - command FFh starts device reset
// - host waits at least 10us after power-up before any command
// - host should keep write_protect_n low across power transitions; the controller holds it low only during srst and the power-up wait
// - ready_busy_n is a wired open-drain line; low means any device busy
// - each page programmed at most once between erases
`timescale 1ns/1ps
`include "nand_ctl_defines.svh"
module nand_ctl
  import nand_ctl_pkg::*;
#(
  parameter int POWERUP_CYCLES = `POWERUP_CYC,
  parameter int RESET_CYCLES = `TRST_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic req_valid,
  input wire op_t req_op,
  output logic req_ready,
  output logic [7:0] rsp_data,
  output logic rsp_valid,
  output logic rsp_last,
  output logic [7:0] status_r,
  output logic wp_enable,
  output pins_t pins_r,
  output logic [7:0] io_out_r,
  output logic io_oe_n,
  input wire logic [7:0] io_in,
  input wire logic ready_busy_in
);
  state_t state_r;
  op_t op_r;
  logic [19:0] wait_r;
  logic [2:0] idx_r;
  logic st_start;
  logic st_low;
  logic st_done;
  logic [7:0] rsp_data_r;
  logic rsp_valid_r;
  logic rsp_last_r;
  logic wp_r;

  nand_strobe #(.WIDTH(`STROBE_CYC)) u_strobe (
    .clk(clk),
    .srst(srst),
    .start(st_start),
    .low(st_low),
    .done(st_done)
  );

  assign req_ready = (state_r == ST_IDLE);
  assign st_start = (state_r == ST_CMD) || (state_r == ST_ADDR) || (state_r == ST_READ);
  assign rsp_data = rsp_data_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_last = rsp_last_r;
  assign wp_enable = wp_r;

  // write protect stays low until power-up recovery is over
  always_ff @(posedge clk) begin
    if (srst) begin
      wp_r <= 1'b0;
    end else if (state_r != ST_POWERUP) begin
      wp_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= ST_POWERUP;
      op_r <= OP_STATUS;
      wait_r <= 20'(POWERUP_CYCLES);
      idx_r <= 3'h0;
    end else begin
      case (state_r)
        ST_POWERUP: begin
          if (wait_r == 20'h00000) begin
            state_r <= ST_IDLE;
          end else begin
            wait_r <= wait_r - 20'h00001;
          end
        end
        ST_IDLE: begin
          idx_r <= 3'h0;
          // no program op is offered, so no page can be programmed twice
          // wired line: any device low holds off a new sequence except reset and status
          if (req_valid && (ready_busy_in || req_op == OP_RESET || req_op == OP_STATUS)) begin
            op_r <= req_op;
            state_r <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (st_done) begin
            if (op_r == OP_READ_ID) begin
              state_r <= ST_ADDR;
            end else if (op_r == OP_RESET) begin
              wait_r <= 20'(`TWB_CYC);
              state_r <= ST_BUSY;
            end else if (op_r == OP_STATUS) begin
              wait_r <= 20'(`TWHR_CYC);
              state_r <= ST_GAP;
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_ADDR: begin
          if (st_done) begin
            wait_r <= 20'(`TWHR_CYC);
            state_r <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (wait_r == 20'h00000) begin
            state_r <= ST_READ;
          end else begin
            wait_r <= wait_r - 20'h00001;
          end
        end
        ST_READ: begin
          if (st_done) begin
            if (op_r == OP_READ_ID && idx_r != 3'(`ID_BYTES - 1)) begin
              idx_r <= idx_r + 3'h1;
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_BUSY: begin
          // wait for the busy onset, then for release, bounded by the reset time
          if (wait_r != 20'h00000) begin
            wait_r <= wait_r - 20'h00001;
            // reload only once, at the end of the busy-onset wait, so the reset bound can run out
            if (wait_r == 20'h00001 && idx_r == 3'h0) begin
              wait_r <= 20'(RESET_CYCLES);
              idx_r <= 3'h1;
            end
          end
          if (idx_r == 3'h1 && (ready_busy_in || wait_r == 20'h00000)) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // pin drive; strobes idle high, chip select low only inside a sequence
  always_ff @(posedge clk) begin
    if (srst) begin
      pins_r <= '{cs_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, read_strobe_n: 1'b1,
                  wp_n: 1'b0};
      io_out_r <= 8'h00;
    end else begin
      pins_r.wp_n <= wp_r;
      pins_r.cs_n <= !(state_r == ST_CMD || state_r == ST_ADDR || state_r == ST_GAP ||
                       state_r == ST_READ);
      pins_r.cle <= (state_r == ST_CMD);
      pins_r.ale <= (state_r == ST_ADDR);
      pins_r.we_n <= !((state_r == ST_CMD || state_r == ST_ADDR) && st_low);
      pins_r.read_strobe_n <= !(state_r == ST_READ && st_low);
      if (state_r == ST_CMD) begin
        case (op_r)
          OP_STATUS: io_out_r <= `CMD_STATUS;
          OP_READ_ID: io_out_r <= `CMD_READ_ID;
          OP_RESET: io_out_r <= `CMD_RESET;
          default: io_out_r <= `CMD_READ;
        endcase
      end else if (state_r == ST_ADDR) begin
        io_out_r <= `ID_ADDR;
      end
    end
  end
  assign io_oe_n = !(state_r == ST_CMD || state_r == ST_ADDR);

  // capture read bytes at the edge that ends the low phase, while the device still drives them
  always_ff @(posedge clk) begin
    if (srst) begin
      rsp_data_r <= 8'h00;
      rsp_valid_r <= 1'b0;
      rsp_last_r <= 1'b0;
      status_r <= `SR_AFTER_RESET;
    end else begin
      rsp_valid_r <= 1'b0;
      rsp_last_r <= 1'b0;
      if (state_r == ST_READ && !pins_r.read_strobe_n && !st_low) begin
        rsp_data_r <= io_in;
        rsp_valid_r <= 1'b1;
        rsp_last_r <= (op_r != OP_READ_ID) || (idx_r == 3'(`ID_BYTES - 1));
        if (op_r == OP_STATUS) begin
          status_r <= io_in;
        end
      end else if (state_r == ST_BUSY && op_r == OP_RESET && ready_busy_in && idx_r == 3'h1) begin
        status_r <= `SR_AFTER_RESET;
      end
    end
  end

  wp_low_a: assert property (@(posedge clk) disable iff (srst)
    state_r == ST_POWERUP |=> !pins_r.wp_n) else $error("write protect high during power-up");
  cmd_latch_a: assert property (@(posedge clk) disable iff (srst)
    !pins_r.we_n |-> !pins_r.cs_n && (pins_r.cle ^ pins_r.ale)) else $error("bad write cycle");
  no_overlap_a: assert property (@(posedge clk) disable iff (srst)
    !(!pins_r.we_n && !pins_r.read_strobe_n)) else $error("read and write strobes overlap");
  id_count_a: assert property (@(posedge clk) disable iff (srst)
    rsp_valid && op_r == OP_READ_ID && idx_r == 3'h0 |-> !rsp_last) else $error("id ends early");
  status_cmd_a: assert property (@(posedge clk) disable iff (srst)
    pins_r.cle && op_r == OP_STATUS |-> io_out_r == `CMD_STATUS) else $error("wrong status code");
  reset_cmd_a: assert property (@(posedge clk) disable iff (srst)
    pins_r.cle && op_r == OP_RESET |-> io_out_r == `CMD_RESET) else $error("wrong reset code");
  id_addr_a: assert property (@(posedge clk) disable iff (srst)
    pins_r.ale |-> io_out_r == `ID_ADDR && op_r == OP_READ_ID) else $error("wrong id address");
  powerup_wait_a: assert property (@(posedge clk) disable iff (srst)
    $fell(srst) |-> pins_r.cs_n [*8]) else $error("command during power-up");
  busy_hold_a: assert property (@(posedge clk) disable iff (srst)
    state_r == ST_BUSY && idx_r == 3'h1 && !ready_busy_in && wait_r != 20'h00000
    |=> state_r == ST_BUSY) else $error("left busy wait early");
endmodule // nand_ctl

// ---- hdl/nand_ctl_defines.svh ----
// timing counts, command codes and status field positions for the nand controller
`ifndef NAND_CTL_DEFINES_SVH
`define NAND_CTL_DEFINES_SVH
`define CLK_PERIOD_NS 8
`define CMD_READ 8'h00
`define CMD_STATUS 8'h70
`define CMD_READ_ID 8'h90
`define CMD_RESET 8'hFF
`define ID_ADDR 8'h00
`define ID_BYTES 5
`define SR_FAIL_BIT 0
`define SR_PL0_BIT 1
`define SR_PL1_BIT 2
`define SR_READY_BIT 6
`define SR_WP_BIT 7
`define SR_AFTER_RESET 8'hC0
`define POWERUP_US 10
`define POWERUP_CYC ((`POWERUP_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_NS 24
`define STROBE_CYC ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TWHR_NS 80
`define TWHR_CYC ((`TWHR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TWB_NS 100
`define TWB_CYC ((`TWB_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TRST_US 500
`define TRST_CYC ((`TRST_US * 1000) / `CLK_PERIOD_NS)
`endif

// ---- hdl/nand_ctl_pkg.sv ----
// types for the nand controller
package nand_ctl_pkg;
  typedef enum logic [1:0] {
    OP_STATUS = 2'h0,
    OP_READ_ID = 2'h1,
    OP_RESET = 2'h2,
    OP_READ_MODE = 2'h3
  } op_t;
  typedef struct packed {
    logic cs_n;
    logic cle;
    logic ale;
    logic we_n;
    logic read_strobe_n;
    logic wp_n;
  } pins_t;
  typedef enum logic [2:0] {
    ST_POWERUP = 3'b000,
    ST_IDLE = 3'b001,
    ST_CMD = 3'b011,
    ST_ADDR = 3'b010,
    ST_GAP = 3'b110,
    ST_READ = 3'b111,
    ST_BUSY = 3'b101
  } state_t;
endpackage

// ---- hdl/nand_strobe.sv ----
// one write or read strobe pulse of fixed width followed by a recovery gap
`timescale 1ns/1ps
`include "nand_ctl_defines.svh"
module nand_strobe #(
  parameter int WIDTH = `STROBE_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  output logic low,
  output logic done
);
  logic [7:0] cnt_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r <= 8'h00;
    end else if (start && cnt_r == 8'h00) begin
      cnt_r <= 8'(2 * WIDTH);
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
  // low half first, high half keeps the hold and cycle time
  assign low = cnt_r > 8'(WIDTH);
  assign done = cnt_r == 8'h01;
endmodule // nand_strobe

// ---- tb/nand_dev_model.sv ----
// behavioural flash device answering status, identification and reset
`timescale 1ns/1ps
module nand_dev_model
  import nand_ctl_pkg::*;
#(
  parameter int BUSY_NS = 202,
  parameter logic [39:0] ID = 40'h5A3C96E10F // identity bytes are arbitrary
) (
  input wire pins_t pins,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic rb_low
);
  logic [7:0] cmd = 8'h00;
  logic [7:0] st = 8'hC0;
  logic [7:0] last = 8'h00;
  logic [7:0] val;
  logic [2:0] idx = 3'h0;
  logic id_mode = 1'b0;
  logic rst_busy = 1'b0;
  event go_rst;
  initial rb_low = 1'b0;
  always @(posedge pins.we_n) begin
    if (!pins.cs_n && pins.cle && !(rst_busy && dq_in == 8'hFF)) begin
      cmd = dq_in;
      id_mode = 1'b0;
      if (dq_in == 8'hFF) begin
        ->go_rst;
      end
    end else if (!pins.cs_n && pins.ale && cmd == 8'h90 && dq_in == 8'h00) begin
      id_mode = 1'b1;
      idx = 3'h0;
    end
  end
  always begin
    @(go_rst);
    rst_busy = 1'b1;
    rb_low = 1'b1;
    st = {pins.wp_n, 7'h00};
    #(BUSY_NS);
    st = {pins.wp_n, 1'b1, 6'h00};
    rb_low = 1'b0;
    rst_busy = 1'b0;
  end
  always @(posedge pins.read_strobe_n) begin
    if (!pins.cs_n && id_mode && idx < 3'h4) begin
      idx = idx + 3'h1;
    end
  end
  // undriven data lines show the inverse of the last byte
  always @* begin
    val = id_mode ? ID[39 - 8 * idx -: 8] : (cmd == 8'h70 ? st : 8'h00);
    if (!pins.cs_n && !pins.read_strobe_n) begin
      dq_out = val;
      last = val;
    end else begin
      dq_out = ~last;
    end
  end
endmodule // nand_dev_model

// ---- tb/test_nand_ctl.sv ----
// self-checking bench for the nand controller against a device model
`timescale 1ns/1ps
module test_nand_ctl;
  import nand_ctl_pkg::*;
  localparam int PU = 20;
  localparam logic [39:0] ID = 40'h5A3C96E10F;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic req_valid = 1'b0;
  op_t req_op = OP_STATUS;
  logic other_busy = 1'b0;
  logic req_ready, rsp_valid, rsp_last, wp_enable, io_oe_n, rb_low, rb;
  logic [7:0] rsp_data, status_r, io_out_r, dq_out, bus;
  pins_t pins_r;
  int failures = 0;
  int n_tests = 0;
  logic [7:0] got [5];
  logic lastf [5];
  assign rb = ~(rb_low | other_busy); // wired line with pull-up
  assign bus = io_oe_n ? dq_out : io_out_r;
  nand_ctl #(.POWERUP_CYCLES(PU), .RESET_CYCLES(50)) dut (.clk(clk), .srst(srst),
    .req_valid(req_valid), .req_op(req_op), .req_ready(req_ready), .rsp_data(rsp_data),
    .rsp_valid(rsp_valid), .rsp_last(rsp_last), .status_r(status_r),
    .wp_enable(wp_enable), .pins_r(pins_r), .io_out_r(io_out_r), .io_oe_n(io_oe_n),
    .io_in(bus), .ready_busy_in(rb));
  nand_dev_model #(.ID(ID)) dev (.pins(pins_r), .dq_in(bus), .dq_out(dq_out),
    .rb_low(rb_low));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic issue(input op_t op);
    int k;
    @(negedge clk);
    req_op = op;
    req_valid = 1'b1;
    for (k = 0; k < 2000 && io_oe_n !== 1'b0; k++) @(negedge clk);
    req_valid = 1'b0;
    chk("taken", 8'h1, 8'(k < 2000));
  endtask
  task automatic collect(input int n);
    int k;
    int b;
    b = 0;
    for (k = 0; k < 400 && b < n; k++) begin
      @(posedge clk);
      #1;
      if (rsp_valid === 1'b1) begin
        got[b] = rsp_data;
        lastf[b] = rsp_last;
        b++;
      end
    end
    chk("bytes", 8'(n), 8'(b));
  endtask
  task automatic t_power;
    int k;
    chk("cs_n", 8'h1, 8'(pins_r.cs_n));
    chk("wp_n", 8'h0, 8'(pins_r.wp_n));
    chk("ready", 8'h0, 8'(req_ready));
    srst = 1'b0;
    for (k = 0; k < 200 && req_ready !== 1'b1; k++) @(negedge clk);
    chk("wait", 8'h1, 8'(k >= PU && k < 200));
    repeat (3) @(negedge clk);
    chk("wp_en", 8'h1, 8'(wp_enable));
    $display("test power done");
  endtask
  task automatic t_status;
    issue(OP_STATUS);
    collect(1);
    chk("status", 8'hC0, got[0]);
    chk("last", 8'h1, 8'(lastf[0]));
    $display("test status done");
  endtask
  task automatic t_id;
    issue(OP_READ_ID);
    collect(5);
    for (int i = 0; i < 5; i++) chk("id", ID[39 - 8 * i -: 8], got[i]);
    chk("id last", 8'h10, {3'h0, lastf[4], lastf[3], lastf[2], lastf[1], lastf[0]});
    $display("test id done");
  endtask
  task automatic t_reset;
    int k;
    int bad;
    bad = 0;
    issue(OP_RESET);
    for (k = 0; k < 100 && rb !== 1'b0; k++) @(negedge clk);
    chk("busy seen", 8'h1, 8'(k < 100));
    while (rb === 1'b0) begin
      bad += (req_ready !== 1'b0);
      @(negedge clk);
    end
    chk("idle in busy", 8'h0, 8'(bad));
    for (k = 0; k < 200 && req_ready !== 1'b1; k++) @(negedge clk);
    chk("status_r", 8'hC0, status_r);
    // line held low by another device: the reset wait must run out on its own
    other_busy = 1'b1;
    issue(OP_RESET);
    for (k = 0; k < 200 && req_ready !== 1'b1; k++) @(negedge clk);
    chk("rst timeout", 8'h1, 8'(k > 63 && k < 100));
    other_busy = 1'b0;
    t_status();
    $display("test reset done");
  endtask
  task automatic t_shared;
    other_busy = 1'b1;
    fork
      begin
        repeat (100) @(negedge clk);
        chk("held off", 8'h1, 8'(io_oe_n));
        other_busy = 1'b0;
      end
      issue(OP_READ_ID);
    join
    collect(5);
    chk("id0", ID[39:32], got[0]);
    issue(OP_READ_MODE);
    repeat (60) @(negedge clk);
    chk("ready", 8'h1, 8'(req_ready));
    $display("test shared done");
  endtask
  initial begin
    #50000;
    failures++;
    close_out();
  end
  initial begin
    repeat (10) @(negedge clk);
    t_power();
    t_status();
    t_id();
    t_reset();
    t_shared();
    close_out();
  end
endmodule // test_nand_ctl
